//--- design/stp_pkg.sv
package stp_pkg;

  // Number of switch ports served by one bridge.
  localparam int NPORT = 24;
  // Width of an absolute port number; ports count from 1, 0 means none.
  localparam int PNUM_W = 5;

  // Bridge priority after reset (32768).
  localparam logic [15:0] BRIDGE_PRIO_RST = 16'h8000;
  // Port identifier of port 1 after reset; each later port adds one.
  localparam logic [15:0] PORT_ID_BASE = 16'h8000;
  // Port priority after reset (128).
  localparam logic [7:0] PORT_PRIO_RST = 8'h80;
  // Recommended path costs for 10, 100 and 1000 Mb/s links.
  localparam logic [31:0] COST_10M = 32'h00000064;
  localparam logic [31:0] COST_100M = 32'h00000013;
  localparam logic [31:0] COST_1G = 32'h00000004;
  // Path cost after reset (19).
  localparam logic [31:0] PATH_COST_RST = COST_100M;
  // Shared group address that every bridge listens on.
  localparam logic [47:0] GROUP_ADDR = 48'h0180C2000000;
  // Hello counter value after reset.
  localparam logic [31:0] HELLO_CNT_RST = 32'h00000000;
  // Dwell counter value on entering a state.
  localparam logic [31:0] DWELL_START = 32'h00000001;

  // The five spanning tree port states.
  typedef enum logic [2:0] {
    ST_DISABLED,
    ST_BLOCKING,
    ST_LISTENING,
    ST_LEARNING,
    ST_FORWARDING
  } stp_state_t;

  // Priority vector; lower compares better, field order sets the ranking.
  typedef struct packed {
    logic [63:0] root_id;
    logic [31:0] root_cost;
    logic [63:0] bridge_id;
    logic [15:0] port_id;
  } stp_prio_vec_t;

  // Per-port configuration set by management.
  typedef struct packed {
    logic [7:0] prio;
    logic [31:0] cost;
    logic [15:0] port_id;
  } stp_port_cfg_t;

  // True when vector a is strictly better than vector b.
  function automatic logic stp_better(input stp_prio_vec_t a, input stp_prio_vec_t b);
    return a < b;
  endfunction : stp_better

endpackage : stp_pkg

//--- design/stp_port_fsm.sv
`timescale 1ns/1ps
// One port's state sequencer, driven by the role the bridge gives it.
module stp_port_fsm (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic forward_role,
  input wire logic [31:0] fwd_delay,
  output stp_pkg::stp_state_t state,
  output logic tx_en,
  output logic learn_en
);

  stp_pkg::stp_state_t state_r; // Current port state.
  stp_pkg::stp_state_t state_nxt; // State for the next edge.
  logic [31:0] cnt_r; // Cycles spent in the current state.
  logic dwell_done; // Forward delay has run out.

  assign dwell_done = cnt_r >= fwd_delay;

  // Next state; a lost role always drops straight back to blocking.
  always_comb begin
    state_nxt = state_r;
    if (!enable) begin
      state_nxt = stp_pkg::ST_DISABLED; // RULE20
    end else begin
      case (state_r)
        stp_pkg::ST_DISABLED: begin
          state_nxt = stp_pkg::ST_BLOCKING; // RULE15
        end
        stp_pkg::ST_BLOCKING: begin
          if (forward_role) begin
            state_nxt = stp_pkg::ST_LISTENING; // RULE14
          end
        end
        stp_pkg::ST_LISTENING: begin
          if (!forward_role) begin
            state_nxt = stp_pkg::ST_BLOCKING; // RULE13
          end else if (dwell_done) begin
            state_nxt = stp_pkg::ST_LEARNING; // RULE21
          end
        end
        stp_pkg::ST_LEARNING: begin
          if (!forward_role) begin
            state_nxt = stp_pkg::ST_BLOCKING; // RULE13
          end else if (dwell_done) begin
            state_nxt = stp_pkg::ST_FORWARDING; // RULE21
          end
        end
        default: begin
          if (!forward_role) begin
            state_nxt = stp_pkg::ST_BLOCKING; // RULE13
          end
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= stp_pkg::ST_DISABLED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Dwell counter restarts on every state change and saturates.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= stp_pkg::DWELL_START;
    end else if (state_nxt != state_r) begin
      cnt_r <= stp_pkg::DWELL_START; // RULE21
    end else if (cnt_r != 32'hFFFFFFFF) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  assign state = state_r;
  // Only forwarding carries data; listening and learning do not.
  assign tx_en = state_r == stp_pkg::ST_FORWARDING; // RULE16 RULE17 RULE19
  assign learn_en = (state_r == stp_pkg::ST_LEARNING) || tx_en; // RULE18

  listen_dwell_a: assert property (@(posedge clock) disable iff (!nrst) // RULE21
    (state_r == stp_pkg::ST_LISTENING && state_nxt == stp_pkg::ST_LEARNING) |-> cnt_r >= fwd_delay)
    else $error("listening ended before forward delay");
  fwd_entry_a: assert property (@(posedge clock) disable iff (!nrst) // RULE21
    $rose(state_r == stp_pkg::ST_FORWARDING) |-> $past(state_r) == stp_pkg::ST_LEARNING)
    else $error("forwarding entered without learning");
  idle_no_tx_a: assert property (@(posedge clock) disable iff (!nrst) // RULE17
    (state_r inside {stp_pkg::ST_BLOCKING, stp_pkg::ST_LISTENING, stp_pkg::ST_LEARNING}) |-> !tx_en)
    else $error("non-forwarding port transmits");

endmodule : stp_port_fsm

//--- design/stp_bridge.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: Bridge id is priority then 48-bit address.
// RULE2: Bridge address is port one's hardware address.
// RULE3: Ports numbered absolutely, starting at one.
// RULE4: Port identifiers default 32768 upward per port.
// RULE5: Each port holds priority, default 128.
// RULE6: Each port holds path cost, default 19.
// RULE7: Periodically send protocol frames to group address.
// RULE8: Group-addressed frames go to protocol, not delivery.
// RULE9: Recompute topology on enable or topology change.
// RULE10: Lowest bridge identifier becomes the root.
// RULE11: Designated bridge has lowest cost to root.
// RULE12: One designated port per segment toward root.
// RULE13: Non-designated ports on duplicate paths are blocked.
// RULE14: Topology change may unblock ports.
// RULE15: Each port in exactly one of five states.
// RULE16: Blocking ports neither transmit nor forward.
// RULE17: Listening ports keep data transmission off.
// RULE18: Learning ports do not yet transmit.
// RULE19: Forwarding ports transmit data frames.
// RULE20: Disabled ports skip data and protocol.
// RULE21: Blocking to forwarding via listening, learning, timed.
module stp_bridge (
  input wire logic clock,
  input wire logic nrst,
  input wire logic stp_enable,
  input wire logic [47:0] mac_port1,
  input wire logic bridge_prio_we,
  input wire logic [15:0] bridge_prio_in,
  input wire logic cfg_we,
  input wire logic [4:0] cfg_port,
  input wire stp_pkg::stp_port_cfg_t cfg_data,
  input wire logic [31:0] fwd_delay,
  input wire logic [31:0] hello_period,
  input wire logic [23:0] port_admin_en,
  input wire logic [23:0] link_up,
  input wire logic rx_valid,
  input wire logic [4:0] rx_port,
  input wire logic [47:0] rx_dst,
  input wire stp_pkg::stp_prio_vec_t rx_bpdu,
  output logic rx_deliver,
  output logic rx_to_stp,
  output logic tx_valid,
  output logic [4:0] tx_port,
  output logic [47:0] tx_dst,
  output stp_pkg::stp_prio_vec_t tx_bpdu,
  output stp_pkg::stp_state_t [23:0] port_state,
  output logic [23:0] port_fwd,
  output logic [23:0] port_learn,
  output logic [63:0] bridge_id,
  output logic [63:0] root_id,
  output logic [31:0] root_cost,
  output logic [4:0] root_port,
  output logic topo_change
);

  logic [15:0] bridge_prio_r; // Bridge priority field.
  stp_pkg::stp_port_cfg_t cfg_r [stp_pkg::NPORT]; // Per-port settings.
  stp_pkg::stp_prio_vec_t info_r [stp_pkg::NPORT]; // Latest message heard per port.
  logic [23:0] info_vld_r; // A message is held for the port.
  logic [23:0] en_vec; // Ports that take part in the protocol.
  logic [23:0] en_prev_r; // Enables seen last cycle.
  logic stp_en_prev_r; // Protocol enable seen last cycle.
  logic info_chg; // A stored message changes this cycle.
  logic recalc_r; // Recompute pulse.
  logic [23:0] role_fwd_r; // Ports whose role lets them forward.
  logic [23:0] desig_r; // Designated ports.
  logic [23:0] role_fwd_c; // Combinational forwarding roles.
  logic [23:0] desig_c; // Combinational designated ports.
  stp_pkg::stp_prio_vec_t best_c; // Best root vector found.
  logic [4:0] root_port_c; // Port that leads to the root, 0 if we are root.
  logic [23:0] tx_pend_r; // Ports still owed a hello frame.
  logic [31:0] hello_cnt_r; // Cycles since the last hello round.
  logic rx_is_group; // Received frame is protocol traffic.
  logic rx_idx_ok; // Received port number is in range.
  logic [4:0] rx_idx; // Zero-based index of the receiving port.
  logic [4:0] cfg_idx; // Zero-based index of the configured port.
  logic tx_any; // Some port is owed a hello.
  logic [4:0] tx_idx; // Lowest port owed a hello.

  // Identifier is priority then port one's address.
  // The address comes from the pin as is.
  assign bridge_id = {bridge_prio_r, mac_port1}; // RULE1 RULE2

  // Absolute port numbers start at 1; 0 and anything above 24 are ignored.
  // Port 0 wraps to index 31 below.
  // Every use of that index is range checked.
  assign cfg_idx = cfg_port - 5'h01; // RULE3
  assign rx_idx = rx_port - 5'h01; // RULE3
  assign rx_idx_ok = (rx_port != 5'h00) && (rx_port <= 5'(stp_pkg::NPORT));

  // A port takes part only while enabled, linked and the protocol runs.
  // Link loss and admin disable look alike.
  // Protocol off takes every port out.
  assign en_vec = {24{stp_enable}} & port_admin_en & link_up;

  // Bridge priority register.
  // Reset gives the default of 32768.
  // A new priority enters the tree at the next recompute.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bridge_prio_r <= stp_pkg::BRIDGE_PRIO_RST; // RULE1
    end else if (bridge_prio_we) begin
      bridge_prio_r <= bridge_prio_in;
    end
  end

  // Per-port settings with their defaults.
  // Writes to port 0 or above 24 are dropped.
  // Port priority is kept but never compared.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int p = 0; p < stp_pkg::NPORT; p++) begin
        cfg_r[p].prio <= stp_pkg::PORT_PRIO_RST; // RULE5
        cfg_r[p].cost <= stp_pkg::PATH_COST_RST; // RULE6
        cfg_r[p].port_id <= stp_pkg::PORT_ID_BASE + 16'(p); // RULE4
      end
    end else if (cfg_we && (cfg_port != 5'h00) && (cfg_port <= 5'(stp_pkg::NPORT))) begin
      cfg_r[cfg_idx] <= cfg_data; // RULE5 RULE6
    end
  end

  // Group-addressed frames are protocol traffic.
  assign rx_is_group = rx_dst == stp_pkg::GROUP_ADDR;
  // Only a message unlike the held one is a change,
  // so steady hellos never restart the tree.
  assign info_chg = rx_valid && rx_is_group && rx_idx_ok && en_vec[rx_idx]
    && (!info_vld_r[rx_idx] || info_r[rx_idx] != rx_bpdu);

  // Store received protocol messages; a port that drops out forgets its peer.
  // No ageing: a lost peer shows only when its port drops.
  // That is simple, but recovery from a silent peer is slow.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      info_vld_r <= 24'h000000;
      for (int p = 0; p < stp_pkg::NPORT; p++) begin
        info_r[p] <= '0;
      end
    end else begin
      info_vld_r <= info_vld_r & en_vec; // RULE20
      if (info_chg) begin
        info_r[rx_idx] <= rx_bpdu; // RULE8
        info_vld_r[rx_idx] <= 1'b1;
      end
    end
  end

  // Frame steering: protocol frames are consumed, data only on forwarding ports.
  // Both answers are registered and stand one cycle.
  // Data on a blocked port is dropped here, not queued.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_deliver <= 1'b0;
      rx_to_stp <= 1'b0;
    end else begin
      rx_to_stp <= rx_valid && rx_idx_ok && rx_is_group && en_vec[rx_idx]; // RULE8 RULE20
      rx_deliver <= rx_valid && rx_idx_ok && !rx_is_group && port_fwd[rx_idx]; // RULE8 RULE16
    end
  end

  // Topology change detection; any change requests a recompute.
  // Registering the request keeps the election off the
  // receive path.
  // A change costs two cycles before roles move.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      en_prev_r <= 24'h000000;
      stp_en_prev_r <= 1'b0;
      recalc_r <= 1'b0;
    end else begin
      en_prev_r <= en_vec;
      stp_en_prev_r <= stp_enable;
      recalc_r <= (stp_enable && !stp_en_prev_r) || (en_vec != en_prev_r) || info_chg; // RULE9
    end
  end

  // Election: lowest vector wins, so lowest root id, then lowest cost.
  // The search is a flat 24-way chain; fine at this rate, deep for faster clocks.
  // Received cost plus link cost wraps at 32 bits;
  // only a peer near the top of the range gets there.
  always_comb begin
    stp_pkg::stp_prio_vec_t cand;
    stp_pkg::stp_prio_vec_t mine;
    // Scratch vectors are cleared first so nothing latches.
    cand = '0;
    mine = '0;
    best_c = '{root_id: bridge_id, root_cost: 32'h0, bridge_id: bridge_id, port_id: 16'h0};
    root_port_c = 5'h00;
    for (int p = 0; p < stp_pkg::NPORT; p++) begin
      if (info_vld_r[p] && en_vec[p]) begin
        cand = info_r[p];
        cand.root_cost = info_r[p].root_cost + cfg_r[p].cost; // RULE11
        if (stp_pkg::stp_better(cand, best_c)) begin
          best_c = cand; // RULE10
          root_port_c = 5'(p + 1);
        end
      end
    end
    for (int p = 0; p < stp_pkg::NPORT; p++) begin
      mine = '{root_id: best_c.root_id, root_cost: best_c.root_cost,
               bridge_id: bridge_id, port_id: cfg_r[p].port_id};
      // Designated where our offer beats whatever the segment already hears.
      desig_c[p] = en_vec[p] && (root_port_c != 5'(p + 1))
        && (!info_vld_r[p] || stp_pkg::stp_better(mine, info_r[p])); // RULE11 RULE12
      // Root port and designated ports forward; the rest block.
      role_fwd_c[p] = desig_c[p] || (root_port_c == 5'(p + 1)); // RULE13
    end
  end

  // Results are taken only on a recompute so the tree stays stable between events.
  // This trades reaction time for a tree that never
  // flickers while messages arrive.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      role_fwd_r <= 24'h000000;
      desig_r <= 24'h000000;
      root_id <= 64'h0;
      root_cost <= 32'h0;
      root_port <= 5'h00;
    end else if (recalc_r) begin
      role_fwd_r <= role_fwd_c; // RULE9 RULE14
      desig_r <= desig_c; // RULE12
      root_id <= best_c.root_id; // RULE10
      root_cost <= best_c.root_cost; // RULE11
      root_port <= root_port_c;
    end
  end

  // Topology change flag, one cycle per recompute.
  // It tells management that roles may have moved.
  // The pulse rises on the same edge as the latch.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      topo_change <= 1'b0;
    end else begin
      topo_change <= recalc_r;
    end
  end

  // One state sequencer per port.
  // Each sees only the latched role.
  // Each port moves on its own dwell counter.
  for (genvar g = 0; g < stp_pkg::NPORT; g++) begin : g_port
    stp_port_fsm u_fsm (
      .clock(clock),
      .nrst(nrst),
      .enable(en_vec[g]),
      .forward_role(role_fwd_r[g]),
      .fwd_delay(fwd_delay),
      .state(port_state[g]),
      .tx_en(port_fwd[g]),
      .learn_en(port_learn[g])
    );
  end

  // Hello timer; each expiry owes a frame to every designated port.
  // A period below 23 starts a round before the last
  // one drains; the new round wins.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hello_cnt_r <= stp_pkg::HELLO_CNT_RST;
    end else if (!stp_enable || hello_cnt_r >= hello_period) begin
      hello_cnt_r <= stp_pkg::HELLO_CNT_RST;
    end else begin
      hello_cnt_r <= hello_cnt_r + 32'h1;
    end
  end

  // Pick the lowest owed port; frames go out one per cycle.
  // Walking downward leaves the lowest port as last hit.
  // A full round of 24 ports takes 24 cycles.
  always_comb begin
    tx_any = 1'b0;
    tx_idx = 5'h00;
    for (int p = stp_pkg::NPORT - 1; p >= 0; p--) begin
      if (tx_pend_r[p]) begin
        tx_any = 1'b1;
        tx_idx = 5'(p);
      end
    end
  end

  // Pending hello frames; a new round wins over the clear of a sent bit.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_pend_r <= 24'h000000;
    end else if (stp_enable && hello_cnt_r >= hello_period) begin
      tx_pend_r <= desig_r & en_vec; // RULE7
    end else begin
      if (tx_any) begin
        tx_pend_r[tx_idx] <= 1'b0;
      end
      // A port that lost its designated role is dropped.
      tx_pend_r <= (tx_pend_r & en_vec & desig_r) & ~(tx_any ? (24'h000001 << tx_idx) : 24'h000000);
    end
  end

  // Outgoing protocol frame carries our view of the root.
  // Data lines hold the last frame between strobes.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tx_valid <= 1'b0;
      tx_port <= 5'h00;
      tx_dst <= 48'h0;
      tx_bpdu <= '0;
    end else begin
      tx_valid <= tx_any && en_vec[tx_idx] && desig_r[tx_idx];
      if (tx_any) begin
        tx_port <= tx_idx + 5'h01; // RULE3
        tx_dst <= stp_pkg::GROUP_ADDR; // RULE7
        tx_bpdu <= '{root_id: root_id, root_cost: root_cost,
                     bridge_id: bridge_id, port_id: cfg_r[tx_idx].port_id};
      end
    end
  end

  // Checks on what the bridge itself drives.
  // Ports 1 and 2 stand for all; the sequencers are alike.
  disabled_quiet_a: assert property (@(posedge clock) disable iff (!nrst) // RULE20
    !en_vec[0] |=> port_state[0] == stp_pkg::ST_DISABLED && !port_fwd[0])
    else $error("disabled port still active");
  group_not_data_a: assert property (@(posedge clock) disable iff (!nrst) // RULE8
    (rx_valid && rx_is_group) |=> !rx_deliver)
    else $error("group frame delivered as data");
  block_no_data_a: assert property (@(posedge clock) disable iff (!nrst) // RULE16
    rx_deliver |-> $past(port_fwd[rx_idx]))
    else $error("data delivered on non-forwarding port");
  blocked_role_a: assert property (@(posedge clock) disable iff (!nrst) // RULE13
    (!role_fwd_r[1] && en_vec[1] && $past(en_vec[1])) |=> port_state[1] != stp_pkg::ST_FORWARDING)
    else $error("non-designated port forwards");
  root_self_a: assert property (@(posedge clock) disable iff (!nrst) // RULE10
    recalc_r |=> (root_port == 5'h00) == (root_id == $past(bridge_id)))
    else $error("root election inconsistent");
  // The lowest owed designated port gets its hello next cycle.
  hello_dest_a: assert property (@(posedge clock) disable iff (!nrst) // RULE7
    (tx_any && en_vec[tx_idx] && desig_r[tx_idx]) |=> tx_valid && tx_dst == stp_pkg::GROUP_ADDR
      && tx_port == $past(tx_idx) + 5'h01)
    else $error("hello not sent to group from owed port");
  root_not_desig_a: assert property (@(posedge clock) disable iff (!nrst) // RULE12
    recalc_r |=> root_port == 5'h00 || !desig_r[root_port - 5'h01])
    else $error("root port also designated");
  change_recalc_a: assert property (@(posedge clock) disable iff (!nrst) // RULE9
    info_chg |=> recalc_r ##1 topo_change)
    else $error("topology change not recomputed");

endmodule : stp_bridge

//--- tb/stp_peer.sv
`timescale 1ns/1ps
// Behavioural peer bridge that hands whole frames to the switch, one strobe per frame.
module stp_peer (
  output logic rx_valid,
  output logic [4:0] rx_port,
  output logic [47:0] rx_dst,
  output stp_pkg::stp_prio_vec_t rx_bpdu,
  input wire logic clock
);
  // Idle lines start low; after a frame they carry its inverse so stale data never looks valid.
  initial begin
    rx_valid = 1'b0;
    rx_port = 5'h00;
    rx_dst = 48'h000000000000;
    rx_bpdu = '0;
  end

  // Drives one frame for exactly one clock, then releases the lines.
  task automatic send(input logic [4:0] port, input logic [47:0] dst, input stp_pkg::stp_prio_vec_t vec);
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_port <= port;
    rx_dst <= dst;
    rx_bpdu <= vec;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_port <= ~port;
    rx_dst <= ~dst;
    rx_bpdu <= ~vec;
  endtask : send
endmodule : stp_peer

//--- tb/stp_bridge_tb.sv
`timescale 1ns/1ps
// Self-checking bench: configuration writes, peer frames and port state walks.
module stp_bridge_tb;
  localparam logic [47:0] MAC = 48'h02ABCDEF0001; // Hardware address of port one.
  localparam logic [47:0] DATA_DST = 48'h02000000BEEF; // Ordinary unicast destination.
  logic clock; // System clock.
  logic nrst; // Active-low reset.
  logic stp_enable, bridge_prio_we, cfg_we;
  logic [15:0] bridge_prio_in;
  logic [4:0] cfg_port;
  stp_pkg::stp_port_cfg_t cfg_data;
  logic [23:0] port_admin_en, link_up;
  logic rx_valid, rx_deliver, rx_to_stp, tx_valid, topo_change;
  logic [4:0] rx_port, tx_port, root_port;
  logic [47:0] rx_dst, tx_dst;
  stp_pkg::stp_prio_vec_t rx_bpdu, tx_bpdu, best, worst;
  stp_pkg::stp_state_t [23:0] port_state;
  logic [23:0] port_fwd, port_learn;
  logic [63:0] bridge_id, root_id;
  logic [31:0] root_cost;
  int num_errors, checked, cycles, n;

  stp_bridge u_stp_bridge (.clock(clock), .nrst(nrst), .stp_enable(stp_enable), .mac_port1(MAC),
    .bridge_prio_we(bridge_prio_we), .bridge_prio_in(bridge_prio_in), .cfg_we(cfg_we), .cfg_port(cfg_port),
    .cfg_data(cfg_data), .fwd_delay(32'h00000004), .hello_period(32'h00000032), .port_admin_en(port_admin_en),
    .link_up(link_up), .rx_valid(rx_valid), .rx_port(rx_port), .rx_dst(rx_dst), .rx_bpdu(rx_bpdu),
    .rx_deliver(rx_deliver), .rx_to_stp(rx_to_stp), .tx_valid(tx_valid), .tx_port(tx_port), .tx_dst(tx_dst),
    .tx_bpdu(tx_bpdu), .port_state(port_state), .port_fwd(port_fwd), .port_learn(port_learn),
    .bridge_id(bridge_id), .root_id(root_id), .root_cost(root_cost), .root_port(root_port),
    .topo_change(topo_change));

  stp_peer u_stp_peer (.rx_valid(rx_valid), .rx_port(rx_port), .rx_dst(rx_dst), .rx_bpdu(rx_bpdu), .clock(clock));

  // Free-running clock, 8 ns period.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // Compares with case equality so an unknown never passes.
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error: %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Checks made %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Bounded wait for a port to reach a state; a miss shows up as a state mismatch.
  task automatic wait_port(input int i, input stp_pkg::stp_state_t st);
    int k;
    k = 0;
    while (port_state[i] !== st && k < 200) begin
      @(posedge clock);
      #1;
      k++;
    end
    check("port state", port_state[i], st);
  endtask : wait_port

  // Counts the cycles a port stays in its present state.
  task automatic dwell(input int i, output int k);
    stp_pkg::stp_state_t st;
    st = port_state[i];
    k = 0;
    while (port_state[i] === st && k < 100) begin
      @(posedge clock);
      #1;
      k++;
    end
  endtask : dwell

  // Bounded wait for a hello frame leaving on port p.
  task automatic wait_tx(input logic [4:0] p);
    int k;
    k = 0;
    while (!(tx_valid === 1'b1 && tx_port === p) && k < 300) begin
      @(posedge clock);
      #1;
      k++;
    end
    check("tx port", tx_port, p);
  endtask : wait_tx

  // Bounded wait for the recompute pulse; the topology outputs are settled by then.
  task automatic wait_topo;
    int k;
    k = 0;
    while (topo_change !== 1'b1 && k < 8) begin
      @(posedge clock);
      #1;
      k++;
    end
    check("topology change", topo_change, 1'b1);
  endtask : wait_topo

  // Writes one port's configuration; priority stays at its default.
  task automatic set_cfg(input logic [4:0] p, input logic [31:0] cost, input logic [15:0] id);
    @(posedge clock);
    cfg_we <= 1'b1;
    cfg_port <= p;
    cfg_data <= '{prio: stp_pkg::PORT_PRIO_RST, cost: cost, port_id: id};
    @(posedge clock);
    cfg_we <= 1'b0;
  endtask : set_cfg

  // Hangs are cut short here and counted as a mismatch.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      $display("Error: run length expected below 5000 seen 5000");
      num_errors++;
      give_verdict();
    end
  end

  // Main sequence of tests.
  initial begin
    {num_errors, checked, cycles} = '0;
    {nrst, stp_enable, bridge_prio_we, cfg_we} = 4'h0;
    bridge_prio_in = 16'h0000;
    cfg_port = 5'h00;
    cfg_data = '0;
    {port_admin_en, link_up} = 48'h000000000000;
    best = '{root_id: 64'h1000000000000001, root_cost: 32'h0000000A, bridge_id: 64'h1000000000000002,
      port_id: 16'h8001};
    worst = '1;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    #1;
    check("bridge id", bridge_id, {stp_pkg::BRIDGE_PRIO_RST, MAC});
    check("port one state", port_state[0], stp_pkg::ST_DISABLED);
    $display("Test reset defaults done");
    // Enabling the protocol with no peers makes this bridge root and walks every port up.
    @(posedge clock);
    {port_admin_en, link_up} <= 48'hFFFFFFFFFFFF;
    stp_enable <= 1'b1;
    wait_port(0, stp_pkg::ST_LISTENING);
    check("listening fwd", {port_fwd[0], port_learn[0]}, 2'h0);
    dwell(0, n);
    check("listening dwell", n, 4);
    check("learning bits", {port_fwd[0], port_learn[0]}, 2'h1);
    dwell(0, n);
    check("learning dwell", n, 4);
    check("forwarding fwd", port_fwd[0], 1'b1);
    check("own root", root_id, bridge_id);
    check("own root port", root_port, 5'h00);
    for (int i = 0; i < 24; i++) begin
      check("state legal", port_state[i] < 5, 1'b1);
    end
    $display("Test port walk done");
    wait_tx(5'h01);
    check("hello dst", tx_dst, stp_pkg::GROUP_ADDR);
    check("hello bridge", tx_bpdu.bridge_id, {stp_pkg::BRIDGE_PRIO_RST, MAC});
    check("hello port one id", tx_bpdu.port_id, stp_pkg::PORT_ID_BASE);
    check("hello cost", tx_bpdu.root_cost, 32'h00000000);
    wait_tx(5'h18);
    check("hello port 24 id", tx_bpdu.port_id, stp_pkg::PORT_ID_BASE + 16'h0017);
    $display("Test hello done");
    // Data and group frames on a forwarding port, then on an administratively disabled port.
    u_stp_peer.send(5'h03, DATA_DST, worst);
    #1;
    check("data deliver", {rx_deliver, rx_to_stp}, 2'h2);
    u_stp_peer.send(5'h03, stp_pkg::GROUP_ADDR, worst);
    #1;
    check("group consumed", {rx_deliver, rx_to_stp}, 2'h1);
    @(posedge clock);
    port_admin_en <= 24'h7FFFFF;
    wait_port(23, stp_pkg::ST_DISABLED);
    u_stp_peer.send(5'h18, DATA_DST, worst);
    #1;
    check("disabled data", {rx_deliver, rx_to_stp}, 2'h0);
    u_stp_peer.send(5'h18, stp_pkg::GROUP_ADDR, worst);
    #1;
    check("disabled group", {rx_deliver, rx_to_stp}, 2'h0);
    $display("Test receive done");
    // A better root heard on port 1, then the same root more cheaply on port 2.
    u_stp_peer.send(5'h01, stp_pkg::GROUP_ADDR, best);
    wait_topo();
    check("new root", root_id, best.root_id);
    check("root cost", root_cost, best.root_cost + stp_pkg::PATH_COST_RST);
    check("root port", root_port, 5'h01);
    set_cfg(5'h02, stp_pkg::COST_1G, stp_pkg::PORT_ID_BASE + 16'h0001);
    u_stp_peer.send(5'h02, stp_pkg::GROUP_ADDR, best);
    wait_topo();
    check("cheaper cost", root_cost, best.root_cost + stp_pkg::COST_1G);
    check("cheaper port", root_port, 5'h02);
    wait_port(0, stp_pkg::ST_BLOCKING);
    check("blocked fwd", {port_fwd[0], port_learn[0]}, 2'h0);
    $display("Test root election done");
    // Losing the cheap link must bring the blocked port back into service.
    @(posedge clock);
    link_up <= 24'hFFFFFD;
    wait_port(0, stp_pkg::ST_LISTENING);
    check("fallback port", root_port, 5'h01);
    wait_port(0, stp_pkg::ST_FORWARDING);
    $display("Test topology change done");
    @(posedge clock);
    bridge_prio_we <= 1'b1;
    bridge_prio_in <= 16'h1000;
    @(posedge clock);
    bridge_prio_we <= 1'b0;
    #1;
    check("new priority", bridge_id, {16'h1000, MAC});
    $display("Test bridge priority done");
    give_verdict();
  end
endmodule : stp_bridge_tb
